// file: core/gscl_regs.vh
`ifndef GSCL_REGS_VH
`define GSCL_REGS_VH
// gray code width and number of column outputs
`define GSCL_CODE_W 7
`define GSCL_NUM_OUT 32
`define GSCL_IDX_W 5
// counter range during conversion
`define GSCL_CNT_RST 7'h00
`define GSCL_CNT_MAX 7'h7f
// fifo shape in the data path
`define GSCL_FIFO_DEPTH 8
`define GSCL_FIFO_AW 3
`endif

// file: core/gscl_fifo.v
`timescale 1ns/1ps
// small synchronous fifo, valid/ready on both sides
module gscl_fifo #(
   parameter WIDTH = 7,
   parameter DEPTH = 8,
   parameter AW = 3
) (
   input wire clk,
   input wire rst,
   input wire ce,
   input wire [WIDTH-1:0] in_data,
   input wire in_valid,
   output wire in_ready,
   output wire [WIDTH-1:0] out_data,
   output wire out_valid,
   input wire out_ready
);
   // storage array
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0] wr_q;
   reg [AW-1:0] rd_q;
   reg [AW:0] cnt_q;
   wire push;
   wire pop;
   assign in_ready = (cnt_q != DEPTH[AW:0]);
   assign out_valid = (cnt_q != {(AW+1){1'b0}});
   assign out_data = mem[rd_q];
   assign push = in_valid & in_ready & ce;
   assign pop = out_valid & out_ready & ce;
   // memory write, no reset needed for data
   always @(posedge clk) begin
      if (push) begin
         mem[wr_q] <= in_data;
      end
   end
   // pointers and fill level
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         wr_q <= {AW{1'b0}};
         rd_q <= {AW{1'b0}};
         cnt_q <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wr_q <= wr_q + 1'b1;
         end
         if (pop) begin
            rd_q <= rd_q + 1'b1;
         end
         if (push & ~pop) begin
            cnt_q <= cnt_q + 1'b1;
         end else if (pop & ~push) begin
            cnt_q <= cnt_q - 1'b1;
         end
      end
   end
endmodule // gscl_fifo

// file: core/gscl_loader.v
// Behaviour
// R1: capture bus only while chain select present
// R2: shift rise with select loads first set
// R3: each later edge loads next set
// R4: after set 32 emit select on exit
// R5: direction pin picks entry pin and order
// R6: controller strobes load after full panel
// R7: load rise clears outputs, copies latches
// R8: data latches reload during conversion
// R9: load fall starts conversion
// R10: step clock increments seven bit counter
// R11: controller starts ramp with step clock
// R12: compare each output code with counter
// R13: top data line is msb; shade n+1
// R14: charge enabled while counter below code
// R15: controller sends select once per line
`timescale 1ns/1ps
`include "gscl_regs.vh"
module gscl_loader (
   input wire clk,
   input wire rst,
   input wire ce,
   input wire dir_ascending,
   input wire [`GSCL_CODE_W-1:0] gray_code_bus,
   input wire shift_edge_clock,
   input wire frame_load_strobe,
   input wire conversion_step_clock,
   input wire chain_in_i,
   output reg chain_in_o,
   output reg chain_in_oe_n,
   input wire chain_out_i,
   output reg chain_out_o,
   output reg chain_out_oe_n,
   output reg [`GSCL_NUM_OUT-1:0] charge_enable,
   output reg converting,
   output reg fifo_stall
);
   // two-flop synchronisers for every pin input
   reg [`GSCL_CODE_W-1:0] bus_s1_q, bus_s2_q;
   reg [4:0] pin_s1_q, pin_s2_q;
   // the direction strap is a pin as well. it resets to ascending, so a
   // board strapped low drives its entry pin for two cycles after reset
   reg dir_s1_q, dir_s2_q;
   wire dir_s;
   assign dir_s = dir_s2_q;
   reg [`GSCL_CODE_W-1:0] bus_s3_q;
   reg sc_s3_q, lc_s3_q, cc_s3_q;
   wire sc_s, lc_s, cc_s, ci_s, co_s;
   assign sc_s = pin_s2_q[0];
   assign lc_s = pin_s2_q[1];
   assign cc_s = pin_s2_q[2];
   assign ci_s = pin_s2_q[3];
   assign co_s = pin_s2_q[4];
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         bus_s1_q <= `GSCL_CNT_RST;
         bus_s2_q <= `GSCL_CNT_RST;
         bus_s3_q <= `GSCL_CNT_RST;
         pin_s1_q <= 5'h00;
         pin_s2_q <= 5'h00;
         dir_s1_q <= 1'b1;
         dir_s2_q <= 1'b1;
         sc_s3_q <= 1'b0;
         lc_s3_q <= 1'b0;
         cc_s3_q <= 1'b0;
      end else if (ce) begin
         bus_s1_q <= gray_code_bus;
         bus_s2_q <= bus_s1_q;
         bus_s3_q <= bus_s2_q;
         pin_s1_q <= {chain_out_i, chain_in_i, conversion_step_clock,
            frame_load_strobe, shift_edge_clock};
         pin_s2_q <= pin_s1_q;
         dir_s1_q <= dir_ascending;
         dir_s2_q <= dir_s1_q;
         sc_s3_q <= sc_s;
         lc_s3_q <= lc_s;
         cc_s3_q <= cc_s;
      end
   end
   // edge events on the synchronised pins
   wire sc_edge, lc_rise, lc_fall, cc_rise, entry_sel;
   assign sc_edge = sc_s ^ sc_s3_q;
   assign lc_rise = lc_s & ~lc_s3_q;
   assign lc_fall = ~lc_s & lc_s3_q;
   assign cc_rise = cc_s & ~cc_s3_q;
   // R5: entry pin choice
   assign entry_sel = dir_s ? ci_s : co_s;
   // internal select state: active flag and slot pointer
   reg active_q;
   reg [`GSCL_IDX_W-1:0] slot_q;
   reg exit_q;
   wire start_load, step_load, capture;
   wire fifo_in_ready, fifo_out_valid;
   wire [`GSCL_CODE_W-1:0] fifo_out_data;
   // R2: rising shift edge with entry select loads first set
   assign start_load = ~active_q & entry_sel & sc_s & ~sc_s3_q;
   // R3: any later shift edge loads the next set
   assign step_load = active_q & sc_edge;
   // R1: captures only under a present select
   assign capture = start_load | step_load;
   // captured codes queue here so the latch write never races the pins
   gscl_fifo #(
      .WIDTH(`GSCL_CODE_W),
      .DEPTH(`GSCL_FIFO_DEPTH),
      .AW(`GSCL_FIFO_AW)
   ) u_fifo (
      .clk(clk),
      .rst(rst),
      .ce(ce),
      .in_data(bus_s3_q),
      .in_valid(capture),
      .in_ready(fifo_in_ready),
      .out_data(fifo_out_data),
      .out_valid(fifo_out_valid),
      .out_ready(~lc_s)
   );
   // slot sequencing of the internal select
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         active_q <= 1'b0;
         slot_q <= {`GSCL_IDX_W{1'b0}};
         exit_q <= 1'b0;
      end else if (ce) begin
         exit_q <= 1'b0;
         if (start_load) begin
            active_q <= 1'b1;
            slot_q <= 5'h01;
         end else if (step_load) begin
            if (slot_q == 5'h1f) begin
               // R4: last set loaded, pass select on
               active_q <= 1'b0;
               slot_q <= 5'h00;
               exit_q <= 1'b1;
            end else begin
               slot_q <= slot_q + 5'h01;
            end
         end
      end
   end
   // write pointer for draining fifo into data latches
   reg [`GSCL_IDX_W-1:0] wslot_q;
   reg [`GSCL_CODE_W-1:0] data_lat [0:`GSCL_NUM_OUT-1];
   reg [`GSCL_CODE_W-1:0] cmp_lat [0:`GSCL_NUM_OUT-1];
   wire [`GSCL_IDX_W-1:0] phys;
   wire drain;
   assign drain = fifo_out_valid & ~lc_s;
   // R5: descending order maps slot k to output 31-k
   assign phys = dir_s ? wslot_q : (5'h1f - wslot_q);
   // R8: data latches keep loading while conversion runs
   always @(posedge clk) begin
      if (ce & drain) begin
         data_lat[phys] <= fifo_out_data;
      end
   end
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         wslot_q <= {`GSCL_IDX_W{1'b0}};
      end else if (ce & drain) begin
         wslot_q <= wslot_q + 5'h01;
      end
   end
   // R7: transfer all data latches on load rise
   integer i;
   always @(posedge clk) begin
      if (ce & lc_rise) begin
         for (i = 0; i < `GSCL_NUM_OUT; i = i + 1) begin
            cmp_lat[i] <= data_lat[i];
         end
      end
   end
   // conversion counter and run flag
   reg [`GSCL_CODE_W-1:0] count_q;
   reg run_q;
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         count_q <= `GSCL_CNT_RST;
         run_q <= 1'b0;
      end else if (ce) begin
         if (lc_rise) begin
            count_q <= `GSCL_CNT_RST;
            run_q <= 1'b0;
         end else if (lc_fall) begin
            // R9: falling load edge starts conversion
            run_q <= 1'b1;
         end else if (run_q & cc_rise) begin
            // R10: step clock advances counter, holds at top
            if (count_q != `GSCL_CNT_MAX) begin
               count_q <= count_q + 7'h01;
            end
         end
      end
   end
   // own loop index, so no variable is written by two processes
   integer j;
   // output registers: pins and per-column charge enables
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         charge_enable <= {`GSCL_NUM_OUT{1'b0}};
         converting <= 1'b0;
         fifo_stall <= 1'b0;
         chain_in_o <= 1'b0;
         chain_out_o <= 1'b0;
         chain_in_oe_n <= 1'b1;
         chain_out_oe_n <= 1'b1;
      end else if (ce) begin
         converting <= run_q;
         fifo_stall <= ~fifo_in_ready;
         // R5: the exit pin is driven, the entry pin released
         chain_out_oe_n <= ~dir_s;
         chain_in_oe_n <= dir_s;
         chain_out_o <= exit_q & dir_s;
         chain_in_o <= exit_q & ~dir_s;
         for (j = 0; j < `GSCL_NUM_OUT; j = j + 1) begin
            if (lc_rise | lc_s) begin
               // R7: outputs cleared on load
               charge_enable[j] <= 1'b0;
            end else begin
               // R12: compare each column with counter
               // R14: charge while counter below code
               // R13: msb is top line, code n is shade n+1
               charge_enable[j] <= run_q & (count_q < cmp_lat[j]);
            end
         end
      end
   end
endmodule // gscl_loader

// file: tb/gscl_chk_asserts.sv
`timescale 1ns/1ps
`include "gscl_regs.vh"
// watches chain pins and charge paths at the loader ports
module gscl_chk (
   input wire clk,
   input wire rst,
   input wire dir_ascending,
   input wire frame_load_strobe,
   input wire chain_in_o,
   input wire chain_in_oe_n,
   input wire chain_out_o,
   input wire chain_out_oe_n,
   input wire [`GSCL_NUM_OUT-1:0] charge_enable,
   input wire converting
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   // dir may pass sync flops, so allow it to settle first
   a_oe_dir_in: assert property ($stable(dir_ascending) [*4] |->
      chain_in_oe_n == dir_ascending) else $error("entry pin drive wrong");
   a_oe_one_side: assert property (1 |=> chain_in_oe_n ^ chain_out_oe_n)
      else $error("both chain pins alike");
   a_exit_out_drv: assert property (chain_out_o |-> !chain_out_oe_n)
      else $error("pulse on undriven out pin");
   a_exit_in_drv: assert property (chain_in_o |-> !chain_in_oe_n)
      else $error("pulse on undriven in pin");
   a_exit_out_one: assert property ($rose(chain_out_o) |=> !chain_out_o)
      else $error("out pulse too long");
   a_exit_in_one: assert property ($rose(chain_in_o) |=> !chain_in_o)
      else $error("in pulse too long");
   a_load_clears: assert property ($rose(frame_load_strobe) |->
      ##[2:6] !(|charge_enable)) else $error("load did not clear");
   a_run_starts: assert property ($fell(frame_load_strobe) |->
      ##[2:6] converting) else $error("run did not start");
   // once settled after a load, charge bits may only drop
   a_charge_falls: assert property ((!frame_load_strobe) [*8] |->
      !(|(charge_enable & ~$past(charge_enable))))
      else $error("charge path re-enabled");
   c_exit_out: cover property ($rose(chain_out_o));
   c_exit_in: cover property ($rose(chain_in_o));
   c_run: cover property ($fell(frame_load_strobe) ##[1:6] converting);
endmodule // gscl_chk
bind gscl_loader gscl_chk u_chk (.clk(clk), .rst(rst),
   .dir_ascending(dir_ascending), .frame_load_strobe(frame_load_strobe),
   .chain_in_o(chain_in_o), .chain_in_oe_n(chain_in_oe_n),
   .chain_out_o(chain_out_o), .chain_out_oe_n(chain_out_oe_n),
   .charge_enable(charge_enable), .converting(converting));

// file: tb/gscl_mcu.sv
`timescale 1ns/1ps
// controller model: bus, clocks, strobes and entry select
module gscl_mcu (
   input wire clk,
   output reg dir_ascending,
   output reg [6:0] gray_code_bus,
   output reg shift_edge_clock,
   output reg frame_load_strobe,
   output reg conversion_step_clock,
   output reg sel_in,
   output reg sel_out
);
   initial begin
      {dir_ascending, gray_code_bus, shift_edge_clock} = 9'h100;
      {frame_load_strobe, conversion_step_clock, sel_in, sel_out} = 4'h0;
   end
   // every pin is held long enough for the sync flops
   task automatic gap;
      repeat (6) @(negedge clk);
   endtask
   // select only with the first rise, new code before each edge
   task automatic send_line(input logic asc);
      int s;
      dir_ascending = asc;
      gap();
      for (s = 0; s < 32; s++) begin
         gray_code_bus = {s[4:0], 2'b11};
         sel_in = asc && s == 0;
         sel_out = !asc && s == 0;
         gap();
         shift_edge_clock = ~shift_edge_clock;
         gap();
      end
   endtask
   // load only after whole line, then drop it
   task automatic pulse_load;
      frame_load_strobe = 1'b1;
      gap();
      frame_load_strobe = 1'b0;
      gap();
   endtask
   task automatic step;
      conversion_step_clock = 1'b1;
      gap();
      conversion_step_clock = 1'b0;
      gap();
   endtask
endmodule // gscl_mcu

// file: tb/tb.sv
`timescale 1ns/1ps
module tb;
   reg clk = 1'b0;
   reg rst = 1'b1;
   wire dir, shc, lds, stc, sel_in, sel_out, ci_o, ci_oe_n, co_o, co_oe_n;
   wire conv, fstall;
   wire [6:0] bus;
   wire [31:0] chg;
   // wire level: device drives when its enable is low
   wire ci_i = ci_oe_n ? sel_in : ci_o;
   wire co_i = co_oe_n ? sel_out : co_o;
   // clock enable, dropped once in each conversion test to show that state freezes
   reg ce = 1'b1;
   integer err_total = 0, samples_checked = 0, exits_in = 0, exits_out = 0;
   gscl_mcu u_mcu (.clk(clk), .dir_ascending(dir), .gray_code_bus(bus),
      .shift_edge_clock(shc), .frame_load_strobe(lds),
      .conversion_step_clock(stc), .sel_in(sel_in), .sel_out(sel_out));
   gscl_loader u_dut (.clk(clk), .rst(rst), .ce(ce), .dir_ascending(dir),
      .gray_code_bus(bus), .shift_edge_clock(shc), .frame_load_strobe(lds),
      .conversion_step_clock(stc), .chain_in_i(ci_i), .chain_in_o(ci_o),
      .chain_in_oe_n(ci_oe_n), .chain_out_i(co_i), .chain_out_o(co_o),
      .chain_out_oe_n(co_oe_n), .charge_enable(chg), .converting(conv),
      .fifo_stall(fstall));
   initial forever #2.5 clk = ~clk;
   // count exit pulses seen on each chain pin, sampled mid-cycle
   always @(negedge clk) begin
      if (ci_o === 1'b1) exits_in = exits_in + 1;
      if (co_o === 1'b1) exits_out = exits_out + 1;
   end
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         $display("unexpected at %0t got %h exp %h", $time, got, exp);
         err_total++;
      end
   endtask
   task automatic finish_test;
      $display("checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // one line in the given order, exit pulse on the far pin only;
   // a charge pattern already running must not move meanwhile
   task automatic test_line(input logic asc);
      logic [31:0] held;
      held = chg;
      exits_in = 0;
      exits_out = 0;
      u_mcu.send_line(asc);
      repeat (8) @(negedge clk);
      check(exits_out, {31'h0, asc});
      check(exits_in, {31'h0, !asc});
      check({31'h0, fstall}, 32'h0);
      check(chg, held);
      $display("line test done");
   endtask
   // clock enable low: a whole step pulse must go unseen
   task automatic test_freeze;
      logic [31:0] held;
      held = chg;
      ce = 1'b0;
      u_mcu.step();
      ce = 1'b1;
      repeat (6) @(negedge clk);
      check(chg, held);
      $display("freeze test done");
   endtask
   // load then step past the top; counter saturates at 127; with reload
   // the next line, in the other order, goes in halfway through
   task automatic test_conv(input logic asc, input logic reload);
      logic [31:0] exp;
      int n, k;
      u_mcu.pulse_load();
      check({31'h0, conv}, 32'h1);
      for (n = 0; n < 130; n++) begin
         for (k = 0; k < 32; k++)
            exp[k] = (n > 127 ? 127 : n) < (asc ? k : 31 - k) * 4 + 3;
         check(chg, exp);
         if (n == 32)
            test_freeze();
         if (n == 64 && reload)
            test_line(!asc);
         u_mcu.step();
      end
      $display("conversion test done");
   endtask
   initial begin
      repeat (12) @(negedge clk);
      rst = 1'b0;
      repeat (4) @(negedge clk);
      test_line(1'b1);
      test_conv(1'b1, 1'b1);
      test_conv(1'b0, 1'b0);
      finish_test();
   end
   // hang guard
   initial begin
      repeat (30000) @(posedge clk);
      err_total++;
      finish_test();
   end
endmodule // tb
